//--- rtl/acrb_pin_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// general-purpose pin drivers
module acrb_pin_ctrl (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // configuration
  input wire logic [2:0] dir,
  input wire logic pin2_source_select,
  input wire logic [2:0] level,
  input wire logic ready,
  // pads
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe
);
  // registered pad drive
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out <= 3'h0;
      pin_oe <= 3'h0;
    end else begin
      pin_oe <= dir;
      pin_out[1:0] <= level[1:0];
      pin_out[2] <= pin2_source_select ? ready : level[2];
    end
  end
endmodule
`default_nettype wire

//--- rtl/acrb_pkg.sv
`default_nettype none
package acrb_pkg;
  // register word indices; the byte address is four times the index
  localparam logic [3:0] IDX_INTEG_EXC = 4'h2;
  localparam logic [3:0] IDX_ROUTING = 4'h3;
  localparam logic [3:0] IDX_PINS = 4'h4;
  // block-local control and interrupt registers
  localparam logic [3:0] IDX_RATE_MODE = 4'h1;
  localparam logic [3:0] IDX_IRQ_STATUS = 4'h8;
  localparam logic [3:0] IDX_IRQ_ENABLE = 4'h9;
  localparam logic [3:0] IDX_IRQ_CLEAR = 4'hA;
  localparam logic [3:0] IDX_CONV_COUNT = 4'hB;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // register 2 fields
  localparam int RDY_BIT = 7;
  localparam int CNT_EN_BIT = 6;
  localparam int CHK_HI = 5;
  localparam int CHK_LO = 4;
  localparam int BURN_BIT = 3;
  localparam int EXC_HI = 2;
  localparam int EXC_LO = 0;
  // register 3 fields
  localparam int R1_HI = 7;
  localparam int R1_LO = 5;
  localparam int R2_HI = 4;
  localparam int R2_LO = 2;
  localparam int RSV3_BIT = 1;
  localparam int AUTO_BIT = 0;
  // register 4 fields
  localparam int RSV4_BIT = 7;
  localparam int DIR_HI = 6;
  localparam int DIR_LO = 4;
  localparam int P2SEL_BIT = 3;
  localparam int LVL_HI = 2;
  localparam int LVL_LO = 0;
  // rate/mode register fields
  localparam int RATE_HI = 7;
  localparam int RATE_LO = 5;
  localparam int TURBO_BIT = 4;
  // interrupt status bits
  localparam int IRQ_READY = 0;
  localparam int IRQ_BAD_CODE = 1;
  // clock and modulator figures
  localparam int PCLK_HZ = 100_000_000;
  localparam int MOD_NORMAL_HZ = 256_000;
  localparam int MOD_TURBO_HZ = 512_000;
  localparam int MOD_DIV_NORMAL = PCLK_HZ / MOD_NORMAL_HZ;
  localparam int MOD_DIV_TURBO = PCLK_HZ / MOD_TURBO_HZ;
  localparam logic [2:0] RATE_RESERVED = 3'h7;
  localparam logic [2:0] ROUTE_RESERVED = 3'h7;
  localparam logic [1:0] CHK_RESERVED = 2'h3;
  // integrity check selection
  typedef enum logic [1:0] {
    ACRB_CHK_OFF = 2'h0,
    ACRB_CHK_INV = 2'h1,
    ACRB_CHK_CRC = 2'h2
  } acrb_chk_t;
  // modulator cycles per result in normal mode, per rate code
  function automatic logic [15:0] acrb_ticks(input logic [2:0] code);
    case (code)
      3'h0: acrb_ticks = 16'h3200; // 20 sps
      3'h1: acrb_ticks = 16'h1639; // 45 sps
      3'h2: acrb_ticks = 16'h0B1C; // 90 sps
      3'h3: acrb_ticks = 16'h05B6; // 175 sps
      3'h4: acrb_ticks = 16'h0306; // 330 sps
      3'h5: acrb_ticks = 16'h01AB; // 600 sps
      3'h6: acrb_ticks = 16'h0100; // 1000 sps
      default: acrb_ticks = 16'h0000; // reserved
    endcase
  endfunction
  // excitation magnitude in microamps
  function automatic logic [10:0] acrb_exc_ua(input logic [2:0] code);
    case (code)
      3'h1: acrb_exc_ua = 11'h00A;
      3'h2: acrb_exc_ua = 11'h032;
      3'h3: acrb_exc_ua = 11'h064;
      3'h4: acrb_exc_ua = 11'h0FA;
      3'h5: acrb_exc_ua = 11'h1F4;
      3'h6: acrb_exc_ua = 11'h3E8;
      3'h7: acrb_exc_ua = 11'h5DC;
      default: acrb_exc_ua = 11'h000;
    endcase
  endfunction
endpackage
`default_nettype wire

//--- rtl/acrb_rate_gen.sv
`timescale 1ns/1ps
`default_nettype none
// modulator tick divider and result-rate counter
module acrb_rate_gen (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // settings
  input wire logic turbo,
  input wire logic [2:0] rate_code,
  // outputs
  output logic result_pulse,
  output logic code_bad
);
  logic [8:0] div_reg; // modulator divider
  logic mod_tick; // one-cycle modulator enable
  logic [15:0] tick_cnt_reg; // modulator ticks toward next result
  logic [15:0] target; // ticks per result

  assign target = acrb_pkg::acrb_ticks(rate_code);
  assign code_bad = (rate_code == acrb_pkg::RATE_RESERVED);

  // divider: doubling the modulator clock doubles every rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      div_reg <= 9'h000;
    end else if (div_reg == 9'((turbo ? acrb_pkg::MOD_DIV_TURBO : acrb_pkg::MOD_DIV_NORMAL) - 1)) begin
      div_reg <= 9'h000;
    end else begin
      div_reg <= div_reg + 9'h001;
    end
  end
  assign mod_tick = (div_reg == 9'h000);

  // result counter, stalled on the reserved rate code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 16'h0000;
      result_pulse <= 1'b0;
    end else begin
      result_pulse <= 1'b0;
      if (code_bad) begin
        tick_cnt_reg <= 16'h0000;
      end else if (mod_tick) begin
        if (tick_cnt_reg >= target - 16'h0001) begin
          tick_cnt_reg <= 16'h0000;
          result_pulse <= 1'b1;
        end else begin
          tick_cnt_reg <= tick_cnt_reg + 16'h0001;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- rtl/acrb_top.sv
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - rate code picks one of seven rates
// - mode bit doubles modulator clock
// - ready flag sets on result, clears on read
// - bit 6 enables the conversion data counter
// - bits 5:4 choose integrity check
// - bit 3 switches burn-out sources
// - bits 2:0 set common excitation current
// - bits 7:5 route excitation source one
// - bits 4:2 route source two, same code
// - bit 0 selects automatic result output
// - register 4 bits 6:4 set pin direction
// - bit 3 drives pin 2 from ready when bit 6 sets pin 2 as an output
// - level bits drive or capture pins
// - registers at 02h-04h, reset 00h
module acrb_top (
  // apb clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // conversion side
  input wire logic result_read,
  // analog controls
  output logic [1:0] integrity_mode,
  output logic burnout_source_enable,
  output logic [10:0] excitation_current_ua,
  output logic [2:0] source1_routing,
  output logic [2:0] source2_routing,
  output logic auto_output,
  output logic turbo_mode,
  // general pins
  input wire logic [2:0] pin_in,
  output logic [2:0] pin_out,
  output logic [2:0] pin_oe,
  // interrupt
  output logic irq
);
  logic [7:0] integ_reg; // register 2 writable fields
  logic [7:0] route_reg; // register 3
  logic [7:0] pins_reg; // register 4
  logic [7:0] rate_reg; // rate and mode
  logic result_ready_flag; // ready flag
  logic [15:0] conv_count_reg; // conversion data counter
  logic [1:0] irq_status_reg; // sticky events
  logic [1:0] irq_enable_reg; // event enables
  logic [2:0] pin_sync_reg; // sampled pin inputs
  logic result_pulse; // new result this cycle
  logic code_bad; // reserved rate selected
  logic code_bad_d_reg; // edge detect for reserved rate
  logic access; // apb access phase
  logic wr_en; // write strobe with low byte lane
  logic rd_en; // read strobe
  logic [3:0] idx; // word index
  logic addr_ok; // mapped word
  logic [7:0] wbyte; // low write byte
  logic [7:0] rd_mux; // read value
  logic wr_integ; // register 2 write hit
  logic wr_route; // register 3 write hit
  logic wr_pins; // register 4 write hit
  logic wr_rate; // rate and mode write hit
  logic wr_irq_en; // interrupt enable write hit
  logic wr_irq_clr; // interrupt clear write hit

  // one completed write to the word at sel
  // the strobe already carries access phase, lane and alignment
  // and pready marks the single edge at which the write lands
  function automatic logic write_hit(input logic strobe, input logic [3:0] at,
    input logic [3:0] sel);
    write_hit = strobe && (at == sel);
  endfunction

  // routing code as applied to a source
  // reserved 111 leaves the source disconnected, so a stray code
  // can never steer excitation current onto an unknown node
  function automatic logic [2:0] route_code(input logic [2:0] code);
    if (code == acrb_pkg::ROUTE_RESERVED) begin
      route_code = 3'h0; // reserved: source off
    end else begin
      route_code = code; // off, analog inputs or references
    end
  endfunction

  // apb decode: access phase, word index and the low write lane
  // only byte lane 0 carries data, the upper lanes are ignored
  // misaligned addresses never produce a write strobe
  assign access = psel && penable;
  assign idx = paddr[5:2];
  assign wbyte = pwdata[7:0];
  assign wr_en = access && pwrite && pstrb[0] && addr_ok && (paddr[1:0] == 2'h0);
  // read data is captured in the setup cycle, ahead of the access edge
  assign rd_en = psel && !penable && !pwrite;

  // per-register write strobes, all taken at the access edge
  assign wr_integ = write_hit(wr_en && pready, idx, acrb_pkg::IDX_INTEG_EXC);
  assign wr_route = write_hit(wr_en && pready, idx, acrb_pkg::IDX_ROUTING);
  assign wr_pins = write_hit(wr_en && pready, idx, acrb_pkg::IDX_PINS);
  assign wr_rate = write_hit(wr_en && pready, idx, acrb_pkg::IDX_RATE_MODE);
  assign wr_irq_en = write_hit(wr_en && pready, idx, acrb_pkg::IDX_IRQ_ENABLE);
  assign wr_irq_clr = write_hit(wr_en && pready, idx, acrb_pkg::IDX_IRQ_CLEAR);

  // address decode for mapped words
  // unmapped words answer with an error and leave every register alone
  always_comb begin
    case (idx)
      acrb_pkg::IDX_RATE_MODE, acrb_pkg::IDX_INTEG_EXC, acrb_pkg::IDX_ROUTING,
      acrb_pkg::IDX_PINS, acrb_pkg::IDX_IRQ_STATUS, acrb_pkg::IDX_IRQ_ENABLE,
      acrb_pkg::IDX_IRQ_CLEAR, acrb_pkg::IDX_CONV_COUNT: begin
        addr_ok = 1'b1;
      end
      default: begin
        addr_ok = 1'b0;
      end
    endcase
  end

  // read value mux
  // write-only clear word and unmapped words read as zero
  // the ready flag is merged in live, never stored in register 2
  always_comb begin
    case (idx)
      acrb_pkg::IDX_RATE_MODE: rd_mux = rate_reg;
      acrb_pkg::IDX_INTEG_EXC: rd_mux = {result_ready_flag, integ_reg[6:0]};
      acrb_pkg::IDX_ROUTING: rd_mux = route_reg;
      acrb_pkg::IDX_PINS: rd_mux = pins_reg;
      acrb_pkg::IDX_IRQ_STATUS: rd_mux = {6'h00, irq_status_reg};
      acrb_pkg::IDX_IRQ_ENABLE: rd_mux = {6'h00, irq_enable_reg};
      acrb_pkg::IDX_CONV_COUNT: rd_mux = conv_count_reg[7:0];
      default: rd_mux = 8'h00;
    endcase
  end

  // apb answer: one wait-free access phase, error on unmapped
  // ready is raised from the setup cycle so it stands in the first
  // access cycle; a master that stretches its access sees it only once
  // read data is registered to keep every output straight from a flop
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(addr_ok && (paddr[1:0] == 2'h0));
      if (rd_en) begin
        prdata <= (idx == acrb_pkg::IDX_CONV_COUNT) ? {16'h0000, conv_count_reg}
                                                    : {24'h000000, rd_mux};
      end
    end
  end

  // register 2 writable fields, ready bit kept out
  // bit 7 is stored as zero and replaced by the live flag on reads
  // so a host write can never fake or drop a pending result
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_reg <= acrb_pkg::CFG_RESET;
    end else if (wr_integ) begin
      integ_reg <= {1'b0, wbyte[6:0]};
    end
  end

  // register 3, reserved bit forced low
  // bit 1 is stored as zero whatever the host writes
  // routing codes are stored raw, the reserved code is handled on output
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      route_reg <= acrb_pkg::CFG_RESET;
    end else if (wr_route) begin
      route_reg <= wbyte & 8'hFD;
    end
  end

  // register 4: outputs keep written level, inputs capture pins
  // the direction written in the same access decides whether the
  // written level is kept or replaced by the pad
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pins_reg <= acrb_pkg::CFG_RESET;
    end else begin
      if (wr_pins) begin
        pins_reg[6:3] <= wbyte[6:3];
        pins_reg[7] <= 1'b0;
      end
      for (int i = 0; i < 3; i++) begin
        if (wr_pins) begin
          // new output keeps the written level, new input samples the pad
          pins_reg[i] <= wbyte[acrb_pkg::DIR_LO + i] ? wbyte[i] : pin_sync_reg[i];
        end else if (!pins_reg[acrb_pkg::DIR_LO + i]) begin
          pins_reg[i] <= pin_sync_reg[i];
        end
      end
    end
  end

  // pin sampling register
  // pad inputs are synchronous already; one stage matches the read path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_sync_reg <= 3'h0;
    end else begin
      pin_sync_reg <= pin_in;
    end
  end

  // rate and mode register
  // bits 7:5 rate code, bit 4 turbo; the low nibble is not stored
  // a rate change keeps the running count unless the new code is the reserved one, which clears it; the new target applies at once
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rate_reg <= acrb_pkg::CFG_RESET;
    end else if (wr_rate) begin
      rate_reg <= wbyte & 8'hF0;
    end
  end

  // ready flag: a new result wins over a simultaneous read
  // losing a result to a read in the same cycle would hide it from
  // the host until the next one, so the set side has priority
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      result_ready_flag <= 1'b0;
    end else if (result_pulse) begin
      result_ready_flag <= 1'b1;
    end else if (result_read) begin
      result_ready_flag <= 1'b0;
    end
  end

  // conversion data counter
  // counts results only while enabled and keeps its value when
  // disabled; it wraps silently after 16 bits
  // the bus shows all 16 bits in the low half of the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      conv_count_reg <= 16'h0000;
    end else if (result_pulse && integ_reg[acrb_pkg::CNT_EN_BIT]) begin
      conv_count_reg <= conv_count_reg + 16'h0001;
    end
  end

  // interrupt enable register
  // same layout as the status word: bit 0 result, bit 1 reserved rate
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_enable_reg <= 2'h0;
    end else if (wr_irq_en) begin
      irq_enable_reg <= wbyte[1:0];
    end
  end

  // sticky status: set beats clear
  // bit 0 flags every new result, bit 1 the step onto the reserved rate
  // a clear that meets a new event in one cycle leaves the bit set
  // the edge detector resets low, matching the idle decode after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_status_reg <= 2'h0;
      code_bad_d_reg <= 1'b0;
    end else begin
      code_bad_d_reg <= code_bad;
      for (int i = 0; i < 2; i++) begin
        if (wr_irq_clr && wbyte[i]) begin
          irq_status_reg[i] <= 1'b0;
        end
      end
      if (result_pulse) begin
        irq_status_reg[acrb_pkg::IRQ_READY] <= 1'b1;
      end
      if (code_bad && !code_bad_d_reg) begin
        irq_status_reg[acrb_pkg::IRQ_BAD_CODE] <= 1'b1;
      end
    end
  end

  // registered control outputs
  // every control output is a flop loaded from its decoded register field, so the
  // analog side never sees decode glitches
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integrity_mode <= 2'h0;
      burnout_source_enable <= 1'b0;
      excitation_current_ua <= 11'h000;
      source1_routing <= 3'h0;
      source2_routing <= 3'h0;
      auto_output <= 1'b0;
      turbo_mode <= 1'b0;
      irq <= 1'b0;
    end else begin
      // reserved check code behaves as disabled
      integrity_mode <= (integ_reg[5:4] == acrb_pkg::CHK_RESERVED) ? 2'(acrb_pkg::ACRB_CHK_OFF)
                                                                 : integ_reg[5:4];
      burnout_source_enable <= integ_reg[acrb_pkg::BURN_BIT];
      excitation_current_ua <= acrb_pkg::acrb_exc_ua(integ_reg[2:0]);
      // reserved routing code leaves the source disconnected
      // both sources share one magnitude but route independently
      source1_routing <= route_code(route_reg[7:5]);
      source2_routing <= route_code(route_reg[4:2]);
      auto_output <= route_reg[acrb_pkg::AUTO_BIT];
      turbo_mode <= rate_reg[acrb_pkg::TURBO_BIT];
      irq <= |(irq_status_reg & irq_enable_reg);
    end
  end

  // result timing
  // one result pulse per rate period; the reserved code stalls it
  // turbo halves the modulator divider, doubling every rate
  acrb_rate_gen u_rate (
    .pclk(pclk),
    .presetn(presetn),
    .turbo(rate_reg[acrb_pkg::TURBO_BIT]),
    .rate_code(rate_reg[7:5]),
    .result_pulse(result_pulse),
    .code_bad(code_bad)
  );

  // pad drivers
  // pad enables follow the direction bits one cycle after a write
  // pin 2 may carry the live ready flag instead of its level bit
  acrb_pin_ctrl u_pins (
    .pclk(pclk),
    .presetn(presetn),
    .dir(pins_reg[6:4]),
    .pin2_source_select(pins_reg[acrb_pkg::P2SEL_BIT]),
    .level(pins_reg[2:0]),
    .ready(result_ready_flag),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .pin_oe(pin_oe)
  );
endmodule
`default_nettype wire

//--- test/acrb_pad_model.sv
`timescale 1ns/1ps
`default_nettype none
// board side of the three general pins: device drives where enabled
module acrb_pad_model (
  // device side
  input wire logic [2:0] pin_out,
  input wire logic [2:0] pin_oe,
  // external source on undriven pins
  input wire logic [2:0] ext_level,
  // level seen by the device
  output logic [2:0] pin_in
);
  // resolve each wire from the enables
  assign pin_in = (pin_oe & pin_out) | (~pin_oe & ext_level);
endmodule
`default_nettype wire

//--- test/acrb_top_asserts.sv
`timescale 1ns/1ps
`default_nettype none
// watches the apb slave and the configuration outputs of the top, except source two routing
module acrb_top_asserts (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [5:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  // configuration outputs
  input wire logic [1:0] integrity_mode,
  input wire logic burnout_source_enable,
  input wire logic [10:0] excitation_current_ua,
  input wire logic [2:0] source1_routing,
  input wire logic auto_output,
  input wire logic turbo_mode,
  input wire logic [2:0] pin_oe
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // completed write on byte lane 0
  logic wr;
  assign wr = psel && penable && pready && pwrite && pstrb[0];
  // last byte written, held for the output checks
  logic [7:0] wd_q;
  // capture write data at the completing edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wd_q <= 8'h00;
    end else if (wr) begin
      wd_q <= pwdata[7:0];
    end
  end
  property p_ans; psel && !penable |=> pready; endproperty
  a_ans: assert property (p_ans) else $error("no answer after setup");
  property p_err; pslverr |-> pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_burn; wr && paddr == 6'h08 |-> ##[1:2] burnout_source_enable == wd_q[3]; endproperty
  a_burn: assert property (p_burn) else $error("burn-out output wrong");
  property p_exc;
    wr && paddr == 6'h08 |-> ##[1:2]
      ((excitation_current_ua == 11'h000) == (wd_q[2:0] == 3'h0));
  endproperty
  a_exc: assert property (p_exc) else $error("excitation off state wrong");
  property p_chk;
    wr && paddr == 6'h08 |-> ##[1:2]
      integrity_mode == ((wd_q[5:4] == 2'h3) ? 2'h0 : wd_q[5:4]);
  endproperty
  a_chk: assert property (p_chk) else $error("integrity mode wrong");
  property p_route;
    wr && paddr == 6'h0C |-> ##[1:2]
      source1_routing == ((wd_q[7:5] == 3'h7) ? 3'h0 : wd_q[7:5]);
  endproperty
  a_route: assert property (p_route) else $error("source one routing wrong");
  property p_auto; wr && paddr == 6'h0C |-> ##[1:2] auto_output == wd_q[0]; endproperty
  a_auto: assert property (p_auto) else $error("output mode wrong");
  property p_dir; wr && paddr == 6'h10 |-> ##[1:2] pin_oe == wd_q[6:4]; endproperty
  a_dir: assert property (p_dir) else $error("pin direction wrong");
  property p_mode; wr && paddr == 6'h04 |-> ##[1:2] turbo_mode == wd_q[4]; endproperty
  a_mode: assert property (p_mode) else $error("mode output wrong");
  property p_rsv;
    psel && pready && !pwrite && paddr == 6'h0C |-> prdata[1] == 1'b0 && prdata[31:8] == 24'h0;
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bit reads one");
endmodule
bind acrb_top acrb_top_asserts u_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pstrb, .prdata, .pready, .pslverr, .integrity_mode, .burnout_source_enable,
  .excitation_current_ua, .source1_routing, .auto_output, .turbo_mode, .pin_oe);
`default_nettype wire

//--- test/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  // bench drive
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic result_read = 1'b0;
  logic [5:0] paddr = 6'h00;
  logic [31:0] pwdata = 32'h0;
  logic [2:0] ext_level = 3'h0;
  // design outputs
  logic [31:0] prdata;
  logic pready, pslverr, burnout_source_enable, auto_output, turbo_mode, irq;
  logic [1:0] integrity_mode;
  logic [10:0] excitation_current_ua;
  logic [2:0] source1_routing, source2_routing, pin_in, pin_out, pin_oe;
  // bookkeeping
  int n_errors = 0;
  int checks_done = 0;
  int cyc = 0;
  int t0;
  logic [31:0] rd;
  logic er;
  localparam logic [5:0] A_RM = {acrb_pkg::IDX_RATE_MODE, 2'b00};
  localparam logic [5:0] A_R2 = {acrb_pkg::IDX_INTEG_EXC, 2'b00};
  localparam logic [5:0] A_R3 = {acrb_pkg::IDX_ROUTING, 2'b00};
  localparam logic [5:0] A_R4 = {acrb_pkg::IDX_PINS, 2'b00};
  localparam logic [5:0] A_ST = {acrb_pkg::IDX_IRQ_STATUS, 2'b00};
  localparam logic [5:0] A_EN = {acrb_pkg::IDX_IRQ_ENABLE, 2'b00};
  localparam logic [5:0] A_CL = {acrb_pkg::IDX_IRQ_CLEAR, 2'b00};
  localparam logic [5:0] A_CN = {acrb_pkg::IDX_CONV_COUNT, 2'b00};
  // excitation magnitudes per code, in microamps
  logic [10:0] exc_tab [8] = '{11'h000, 11'h00A, 11'h032, 11'h064, 11'h0FA, 11'h1F4,
    11'h3E8, 11'h5DC};
  // 100 mhz clock
  always #5 pclk = ~pclk;
  acrb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF),
    .prdata, .pready, .pslverr, .result_read, .integrity_mode, .burnout_source_enable,
    .excitation_current_ua, .source1_routing, .source2_routing, .auto_output, .turbo_mode,
    .pin_in, .pin_out, .pin_oe, .irq);
  acrb_pad_model u_pads (.pin_out, .pin_oe, .ext_level, .pin_in);
  // verdict and end of run
  task test_done;
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  // compare one value
  task cmp(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task apb(input logic w, input logic [5:0] a, input logic [31:0] d, output logic [31:0] r,
    output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task wr(input logic [5:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rd, er);
  endtask
  task rdx(input logic [5:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0, rd, er);
    cmp(rd, exp);
  endtask
  // let derived outputs follow a write
  task settle;
    repeat (2) @(posedge pclk);
  endtask
  // hang guard
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      n_errors++;
      test_done;
    end
  end
  // main sequence
  initial begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    for (int i = 0; i < 3; i++) rdx(A_R2 + 6'(4 * i), 32'h0);
    cmp(pin_oe, 32'h0);
    for (int i = 0; i < 8; i++) begin
      wr(A_R2, {24'h0, 2'b11, i[1:0], i[0], i[2:0]});
      settle;
      cmp(excitation_current_ua, exc_tab[i]);
      cmp(integrity_mode, (i[1:0] == 2'h3) ? 2'h0 : i[1:0]);
      cmp(burnout_source_enable, i[0]);
      rdx(A_R2, {24'h0, 2'b01, i[1:0], i[0], i[2:0]});
    end
    $display("test reg2 done");
    for (int i = 0; i < 8; i++) begin
      wr(A_R3, {24'h0, i[2:0], i[2:0], 2'b01});
      settle;
      cmp(source1_routing, (i == 7) ? 3'h0 : i[2:0]);
      cmp(source2_routing, (i == 7) ? 3'h0 : i[2:0]);
      cmp(auto_output, 1'b1);
      rdx(A_R3, {24'h0, i[2:0], i[2:0], 2'b01});
    end
    wr(A_R3, 32'h0);
    settle;
    cmp(auto_output, 1'b0);
    $display("test reg3 done");
    wr(A_R4, 32'h00000075);
    settle;
    cmp(pin_oe, 32'h7);
    cmp(pin_out, 32'h5);
    rdx(A_R4, 32'h75);
    ext_level <= 3'h6;
    wr(A_R4, 32'h0);
    repeat (4) @(posedge pclk);
    cmp(pin_oe, 32'h0);
    rdx(A_R4, 32'h6);
    apb(1'b0, 6'h3C, 32'h0, rd, er);
    cmp(er, 1'b1);
    cmp(rd, 32'h0);
    $display("test pins done");
    wr(A_R4, 32'h48);
    wr(A_EN, 32'h1);
    wr(A_R2, 32'h7F);
    wr(A_RM, 32'hD0);
    t0 = cyc;
    settle;
    cmp(turbo_mode, 1'b1);
    while (irq !== 1'b1) @(posedge pclk);
    cmp(cyc - t0 >= 48000 && cyc - t0 <= 51000, 1'b1);
    rdx(A_ST, 32'h1);
    rdx(A_R2, 32'hFF);
    cmp(pin_out[2], 1'b1);
    rdx(A_CN, 32'h1);
    wr(A_R2, 32'h3F);
    rdx(A_R2, 32'hBF);
    @(posedge pclk);
    result_read <= 1'b1;
    @(posedge pclk);
    result_read <= 1'b0;
    settle;
    rdx(A_R2, 32'h3F);
    cmp(pin_out[2], 1'b0);
    wr(A_CL, 32'h1);
    settle;
    cmp(irq, 1'b0);
    rdx(A_ST, 32'h0);
    $display("test conversion done");
    test_done;
  end
endmodule
`default_nettype wire
